// ===== verilog/hubi2c_pkg.sv
`default_nettype none
package hubi2c_pkg;
  // ----------------------------------------
  // Addressing
  // ----------------------------------------
  localparam logic [6:0] ADDR_STRAP_HI = 7'h29;
  localparam logic [6:0] ADDR_STRAP_LO = 7'h28;
  localparam int         BYTE_BITS     = 8;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int STRAP_HOLD_NS   = 10;
  localparam int STRAP_HOLD_CYC  =
    ((STRAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((STRAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int HS_RATE_KBPS    = 3400;
  localparam logic [7:0] IDX_RESET = 8'h00;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
    logic [7:0] data;
  } hubi2c_req_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } hubi2c_bus_type;
endpackage
`default_nettype wire

// ===== verilog/hubi2c_target.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RULE_01: Device only responds, never starts transfers
// RULE_02: Passive until own address matches
// RULE_03: Strap high gives 0x29, low 0x28
// RULE_04: Strap must hold 10 ns after reset
// RULE_05: Strap pin becomes general I/O later
// RULE_06: Bytes of eight bits, clocked by SCL
// RULE_07: Single and multi byte reads, writes
// RULE_08: Host drives clock; data shared by direction
// RULE_09: Open-drain only, pull-ups make high
// RULE_10: Works up to 3.4 Mbit/s
// RULE_11: First app pin low until init done
// RULE_12: Read: index write, repeated start, read
// RULE_13: One dedicated host interrupt output
// RULE_14: Write: address, index, data, stop
// RULE_15: Index advances after each data byte
module hubi2c_target
  import hubi2c_pkg::*;
#(
  parameter int DEPTH = 2
)(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_scl,
  input  wire logic                  i_sda,
  output logic                       o_sda_oe_n,
  output logic                       o_scl_oe_n,
  input  wire logic                  i_addr_strap_io,
  input  wire logic                  i_strap_io_out,
  input  wire logic                  i_strap_io_oe,
  output logic                       o_addr_strap_io_out,
  output logic                       o_addr_strap_io_oe_n,
  input  wire logic                  i_init_done,
  output logic                       o_app_io_first_oe_n,
  input  wire logic                  i_irq,
  output logic                       o_irq_oe_n,
  output logic                       o_req_valid,
  output hubi2c_pkg::hubi2c_req_type o_req,
  input  wire logic                  i_req_ready,
  input  wire logic [7:0]            i_rd_data
);
  import hubi2c_pkg::*;

  // ----------------------------------------
  // Input synchronisers and edges
  // ----------------------------------------
  logic [1:0] scl_s_q, sda_s_q, strap_s_q;
  logic [1:0] scl_s_d, sda_s_d, strap_s_d;
  logic       scl_p_q, sda_p_q, scl_p_d, sda_p_d;
  logic       scl_rise, scl_fall, start_c, stop_c;

  always_comb
  begin
    scl_s_d   = {scl_s_q[0], i_scl};                // [RULE_10]
    sda_s_d   = {sda_s_q[0], i_sda};
    strap_s_d = {strap_s_q[0], i_addr_strap_io};
    scl_p_d   = scl_s_q[1];
    sda_p_d   = sda_s_q[1];
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      scl_s_q   <= 2'h3;
      sda_s_q   <= 2'h3;
      strap_s_q <= 2'h0;
      scl_p_q   <= 1'b1;
      sda_p_q   <= 1'b1;
    end
    else
    begin
      scl_s_q   <= scl_s_d;
      sda_s_q   <= sda_s_d;
      strap_s_q <= strap_s_d;
      scl_p_q   <= scl_p_d;
      sda_p_q   <= sda_p_d;
    end
  end

  assign scl_rise = scl_s_q[1] & ~scl_p_q;
  assign scl_fall = ~scl_s_q[1] & scl_p_q;
  assign start_c  = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
  assign stop_c   = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  logic [2:0] hold_cnt_q, hold_cnt_d;
  logic       latched_q, latched_d, strap_q, strap_d;
  logic [6:0] own_addr;

  always_comb
  begin
    hold_cnt_d = hold_cnt_q;
    latched_d  = latched_q;
    strap_d    = strap_q;
    if (!latched_q)
    begin
      if (hold_cnt_q == 3'(STRAP_HOLD_CYC + 2))
      begin
        latched_d = 1'b1;                         // [RULE_04]
        strap_d   = strap_s_q[1];
      end
      else
        hold_cnt_d = hold_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hold_cnt_q <= 3'h0;
      latched_q  <= 1'b0;
      strap_q    <= 1'b0;
    end
    else
    begin
      hold_cnt_q <= hold_cnt_d;
      latched_q  <= latched_d;
      strap_q    <= strap_d;
    end
  end

  assign own_addr = strap_q ? ADDR_STRAP_HI : ADDR_STRAP_LO;   // [RULE_03]

  // ----------------------------------------
  // Target state machine
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
  } hubi2c_state_type;

  hubi2c_state_type st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, idx_q, idx_d;
  logic       rw_q, rw_d, have_idx_q, have_idx_d, ack_q, ack_d;
  logic       sda_drv_q, sda_drv_d, push;
  hubi2c_req_type push_req;
  logic [1:0] cnt_q, cnt_d;

  always_comb
  begin
    st_d       = st_q;
    bit_d      = bit_q;
    sh_d       = sh_q;
    idx_d      = idx_q;
    rw_d       = rw_q;
    have_idx_d = have_idx_q;
    ack_d      = ack_q;
    sda_drv_d  = sda_drv_q;
    push       = 1'b0;
    push_req   = '{wr: 1'b1, idx: idx_q, data: sh_q};
    if (start_c && latched_q)                     // [RULE_01]
    begin
      st_d      = ST_ADDR;
      bit_d     = 4'h0;
      sda_drv_d = 1'b0;
    end
    else if (stop_c)
    begin
      st_d      = ST_IDLE;
      sda_drv_d = 1'b0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE: ;
        ST_ADDR, ST_RX:
        begin
          if (scl_rise)
          begin
            sh_d  = {sh_q[6:0], sda_s_q[1]};       // [RULE_06]
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall && bit_q == 4'(BYTE_BITS))
          begin
            if (st_q == ST_ADDR)
            begin
              if (sh_q[7:1] == own_addr)           // [RULE_02]
              begin
                rw_d      = sh_q[0];
                sda_drv_d = 1'b1;
                st_d      = ST_ADDR_ACK;
              end
              else
                st_d = ST_IDLE;
            end
            else if (i_req_ready || !have_idx_q || cnt_q != 2'(DEPTH))
            begin
              sda_drv_d = 1'b1;                   // [RULE_14]
              st_d      = ST_RX_ACK;
              if (!have_idx_q)
              begin
                idx_d      = sh_q;
                have_idx_d = 1'b1;
              end
              else
              begin
                push  = 1'b1;                     // [RULE_07]
                idx_d = idx_q + 8'h1;             // [RULE_15]
              end
            end
            else
              st_d = ST_IDLE;
          end
        end
        ST_ADDR_ACK, ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            bit_d = 4'h0;
            if (st_q == ST_ADDR_ACK && rw_q)      // [RULE_12]
            begin
              sh_d      = i_rd_data;
              sda_drv_d = ~i_rd_data[7];
              st_d      = ST_TX;
            end
            else
            begin
              sda_drv_d = 1'b0;
              if (st_q == ST_ADDR_ACK)
                have_idx_d = 1'b0;
              st_d = ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'(BYTE_BITS - 1))
            begin
              sda_drv_d = 1'b0;
              st_d      = ST_TX_ACK;
            end
            else
            begin
              sh_d      = {sh_q[6:0], 1'b0};
              sda_drv_d = ~sh_q[6];
            end
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise)
            ack_d = ~sda_s_q[1];
          if (scl_fall)
          begin
            if (ack_q)
            begin
              idx_d     = idx_q + 8'h1;           // [RULE_15]
              sh_d      = i_rd_data;
              sda_drv_d = ~i_rd_data[7];
              bit_d     = 4'h0;
              st_d      = ST_TX;
            end
            else
              st_d = ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q       <= ST_IDLE;
      bit_q      <= 4'h0;
      sh_q       <= 8'h00;
      idx_q      <= IDX_RESET;
      rw_q       <= 1'b0;
      have_idx_q <= 1'b0;
      ack_q      <= 1'b0;
      sda_drv_q  <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      bit_q      <= bit_d;
      sh_q       <= sh_d;
      idx_q      <= idx_d;
      rw_q       <= rw_d;
      have_idx_q <= have_idx_d;
      ack_q      <= ack_d;
      sda_drv_q  <= sda_drv_d;
    end
  end

  // ----------------------------------------
  // Two-entry write buffer
  // ----------------------------------------
  hubi2c_req_type buf_q [DEPTH];
  hubi2c_req_type buf_d [DEPTH];
  logic       pop;

  assign pop = o_req_valid & i_req_ready;

  always_comb
  begin
    buf_d = buf_q;
    cnt_d = cnt_q;
    if (pop)
    begin
      buf_d[0] = buf_q[1];
      cnt_d    = cnt_d - 2'h1;
    end
    if (push && cnt_d != 2'(DEPTH))
    begin
      buf_d[cnt_d[0]] = push_req;
      cnt_d           = cnt_d + 2'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      cnt_q    <= 2'h0;
    end
    else
    begin
      buf_q <= buf_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sda_oe_n           <= 1'b1;
      o_scl_oe_n           <= 1'b1;
      o_addr_strap_io_out  <= 1'b0;
      o_addr_strap_io_oe_n <= 1'b1;
      o_app_io_first_oe_n  <= 1'b0;
      o_irq_oe_n           <= 1'b1;
      o_req_valid          <= 1'b0;
      o_req                <= '0;
    end
    else
    begin
      o_sda_oe_n           <= ~sda_drv_d;                       // [RULE_09]
      o_scl_oe_n           <= 1'b1;                             // [RULE_08]
      o_addr_strap_io_out  <= i_strap_io_out;
      o_addr_strap_io_oe_n <= ~(latched_q & i_strap_io_oe);     // [RULE_05]
      o_app_io_first_oe_n  <= i_init_done;                      // [RULE_11]
      o_irq_oe_n           <= ~i_irq;                           // [RULE_13]
      o_req_valid          <= cnt_d != 2'h0;
      o_req                <= buf_d[0];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence addr_byte_s;
    st_q == ST_ADDR && scl_fall && bit_q == 4'h8;
  endsequence

  no_self_start_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_01]
    $rose(st_q == ST_ADDR) |-> $past(start_c)) else $error("addr phase without start");
  addr_match_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_02]
    addr_byte_s ##0 sh_q[7:1] != own_addr |=> st_q == ST_IDLE) else $error("foreign addr acked");
  addr_select_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_03]
    $rose(latched_q) |-> strap_q == $past(strap_s_q[1])) else $error("strap not captured");
  strap_stable_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_05]
    latched_q |=> $stable(strap_q)) else $error("strap changed");
  scl_release_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_08]
    o_scl_oe_n) else $error("clock line driven");
  sda_idle_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_09]
    st_q == ST_IDLE ##1 st_q == ST_IDLE |-> o_sda_oe_n) else $error("sda held in idle");
  app_low_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_11]
    !i_init_done |=> !o_app_io_first_oe_n) else $error("app pin released early");
  idx_step_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_15]
    push |=> idx_q == $past(idx_q) + 8'h1) else $error("index not advanced");
endmodule
`default_nettype wire

// ===== verification/hubi2c_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host bus controller model
// ----------------------------------------
module hubi2c_host_model #(
  parameter int Q_NS = 40
)(
  input  wire logic i_sda,
  output logic      o_scl_low,
  output logic      o_sda_low
);
  initial
  begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end

  // Start or repeated start, only ever begun here
  task automatic start();
    #1;
    o_sda_low = 1'b0;
    #Q_NS;
    o_scl_low = 1'b0;
    #Q_NS;
    o_sda_low = 1'b1;
    #Q_NS;
    o_scl_low = 1'b1;
    #Q_NS;
  endtask

  // Stop, then clock stands still high
  task automatic stop();
    o_sda_low = 1'b1;
    #Q_NS;
    o_scl_low = 1'b0;
    #Q_NS;
    o_sda_low = 1'b0;
    #Q_NS;
  endtask

  // One bit, clock made by host only
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = ~b;
    #Q_NS;
    o_scl_low = 1'b0;
    #Q_NS;
    r = i_sda;
    #Q_NS;
    o_scl_low = 1'b1;
    #Q_NS;
  endtask

  // Byte out MSB first, returns acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Byte in, then host acknowledge or not
  task automatic rbyte(input logic ack_it, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(~ack_it, r);
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import hubi2c_pkg::*;
  logic clk, rst, strap, st_out, st_oe, init_done, irq, ready;
  logic [7:0] rd_data;
  logic scl_low, sda_low, sda_oe_n, scl_oe_n, req_valid;
  logic strap_out, strap_oe_n, app_oe_n, irq_oe_n, a;
  logic [7:0] d;
  hubi2c_req_type req;
  hubi2c_req_type got[$];
  wire logic scl_w = ~(scl_low | ~scl_oe_n);
  wire logic sda_w = ~(sda_low | ~sda_oe_n);
  int err_count = 0;
  int compares = 0;

  hubi2c_target u_dut (
    .i_clk(clk), .i_rst(rst), .i_scl(scl_w), .i_sda(sda_w),
    .o_sda_oe_n(sda_oe_n), .o_scl_oe_n(scl_oe_n), .i_addr_strap_io(strap),
    .i_strap_io_out(st_out), .i_strap_io_oe(st_oe), .o_addr_strap_io_out(strap_out),
    .o_addr_strap_io_oe_n(strap_oe_n), .i_init_done(init_done),
    .o_app_io_first_oe_n(app_oe_n), .i_irq(irq), .o_irq_oe_n(irq_oe_n),
    .o_req_valid(req_valid), .o_req(req), .i_req_ready(ready), .i_rd_data(rd_data)
  );
  hubi2c_host_model u_host (.i_sda(sda_w), .o_scl_low(scl_low), .o_sda_low(sda_low));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
    if (req_valid === 1'b1 && ready === 1'b1)
      got.push_back(req);

  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] s);
    compares++;
    if (e !== s)
    begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask

  task automatic end_sim();
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst <= 1'b1;
    strap <= s;
    init_done <= 1'b0;
    st_oe <= 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  task automatic t_write();
    do_reset(1'b1);
    got.delete();
    u_host.start();
    u_host.wbyte({ADDR_STRAP_HI, 1'b0}, a);
    chk("wr_ack", 17'h1, {16'h0, a});
    u_host.wbyte(8'h10, a);
    u_host.wbyte(8'h5a, a);
    u_host.wbyte(8'hc3, a);
    chk("wr_ack3", 17'h1, {16'h0, a});
    u_host.stop();
    repeat (20) @(posedge clk);
    chk("req0", {1'b1, 8'h10, 8'h5a}, got[0]);
    chk("req1", {1'b1, 8'h11, 8'hc3}, got[1]);
    chk("scl_oe", 17'h1, {16'h0, scl_oe_n});
  endtask

  task automatic t_foreign();
    got.delete();
    u_host.start();
    u_host.wbyte({ADDR_STRAP_LO, 1'b0}, a);
    chk("other_ack", 17'h0, {16'h0, a});
    u_host.wbyte(8'h77, a);
    u_host.stop();
    repeat (20) @(posedge clk);
    chk("other_req", 17'h0, 17'(got.size()));
  endtask

  task automatic t_read();
    @(posedge clk) rd_data <= 8'ha5;
    u_host.start();
    u_host.wbyte({ADDR_STRAP_HI, 1'b0}, a);
    u_host.wbyte(8'h20, a);
    u_host.start();
    u_host.wbyte({ADDR_STRAP_HI, 1'b1}, a);
    chk("rd_ack", 17'h1, {16'h0, a});
    fork
      u_host.rbyte(1'b1, d);
      begin
        #1220;
        @(posedge clk) rd_data <= 8'h3c;
      end
    join
    chk("rd0", 17'h0a5, {9'h0, d});
    u_host.rbyte(1'b0, d);
    chk("rd1", 17'h03c, {9'h0, d});
    u_host.stop();
  endtask

  task automatic t_stall();
    got.delete();
    @(posedge clk) ready <= 1'b0;
    u_host.start();
    u_host.wbyte({ADDR_STRAP_HI, 1'b0}, a);
    u_host.wbyte(8'h40, a);
    u_host.wbyte(8'h11, a);
    u_host.wbyte(8'h22, a);
    chk("buf_ack", 17'h1, {16'h0, a});
    u_host.wbyte(8'h33, a);
    chk("full_nack", 17'h0, {16'h0, a});
    u_host.stop();
    @(posedge clk) ready <= 1'b1;
    repeat (20) @(posedge clk);
    chk("drain0", {1'b1, 8'h40, 8'h11}, got[0]);
    chk("drain1", {1'b1, 8'h41, 8'h22}, got[1]);
    chk("drain_n", 17'h2, 17'(got.size()));
  endtask

  task automatic t_strap_low();
    do_reset(1'b0);
    chk("app_low", 17'h0, {16'h0, app_oe_n});
    init_done <= 1'b1;
    irq <= 1'b1;
    strap <= 1'b1;
    st_oe <= 1'b1;
    st_out <= 1'b1;
    repeat (6) @(posedge clk);
    chk("app_free", 17'h1, {16'h0, app_oe_n});
    chk("irq_low", 17'h0, {16'h0, irq_oe_n});
    chk("io_oe", 17'h0, {16'h0, strap_oe_n});
    chk("io_out", 17'h1, {16'h0, strap_out});
    irq <= 1'b0;
    repeat (6) @(posedge clk);
    chk("irq_free", 17'h1, {16'h0, irq_oe_n});
    u_host.start();
    u_host.wbyte({ADDR_STRAP_HI, 1'b0}, a);
    chk("hi_nack", 17'h0, {16'h0, a});
    u_host.stop();
    u_host.start();
    u_host.wbyte({ADDR_STRAP_LO, 1'b0}, a);
    chk("lo_ack", 17'h1, {16'h0, a});
    u_host.stop();
  endtask

  initial
  begin
    rst = 1'b1;
    strap = 1'b1;
    st_out = 1'b0;
    st_oe = 1'b0;
    init_done = 1'b0;
    irq = 1'b0;
    ready = 1'b1;
    rd_data = 8'h00;
    t_write();
    t_foreign();
    t_read();
    t_stall();
    t_strap_low();
    end_sim();
  end

  initial
  begin
    #500000;
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
